// ===== shared/ats_pkg.sv
// package for the autotune save and configuration block: constants, fields, types
// assumes one 10 MHz clock and a host that sends one adjust frame at a time
//
// Contract
// - adjust frame is code 3E with byte 00
// - mode select gives good answer, ready set
// - save completes, then command ready reported
// - unsaved tuning lost, power-on uses defaults
// - saved results load at next power-on
// - inertia ratio 0 to 10000, default 0
// - method 0 first run, 1 continuous, 2 off
// - speed feedback comp 0 on, 1 off
// - friction comp 0 off, 1 small, 2 large
// - estimate clamped at thirty times motor inertia
// - manual speed feedback setting is applied
// - answer echoes code, location and payload
// - good answer has alarm and warning clear
package ats_pkg;

	localparam logic [7:0]  ADJ_CODE        = 8'h3E;
	localparam logic [7:0]  ADJ_EXT         = 8'h00;
	localparam logic [7:0]  SUB_DATA_SET    = 8'h01;
	localparam logic [15:0] LOC_MODE        = 16'h2000;
	localparam logic [15:0] LOC_EXEC        = 16'h2001;
	localparam logic [15:0] MODE_RESULTS_WR = 16'h1007;
	localparam logic [15:0] EXEC_VALUE      = 16'h0001;

	localparam logic [3:0]  OFF_RATIO       = 4'h0;
	localparam logic [3:0]  OFF_OPTION      = 4'h4;
	localparam logic [3:0]  OFF_STATUS      = 4'h8;

	localparam logic [15:0] RATIO_MAX       = 16'h2710;
	localparam logic [15:0] RATIO_CLAMP     = 16'h0BB8;
	localparam logic [15:0] RATIO_RESET     = 16'h0000;

	localparam int          METHOD_LSB      = 0;
	localparam int          SFB_LSB         = 4;
	localparam int          FRIC_LSB        = 8;
	localparam logic [3:0]  METHOD_RESET    = 4'h0;
	localparam logic [3:0]  SFB_RESET       = 4'h1;
	localparam logic [3:0]  FRIC_RESET      = 4'h0;
	localparam logic [15:0] OPTION_RESET    = 16'h0010;

	localparam logic [1:0]  NVM_RATIO       = 2'h0;
	localparam logic [1:0]  NVM_OPTION      = 2'h1;
	localparam logic [1:0]  NVM_MARK        = 2'h2;
	// arbitrary marker value
	localparam logic [15:0] SAVE_MARK       = 16'hA5C3;

	localparam int          CLK_HZ          = 10000000;
	localparam int          SAVE_TIME_MS    = 1000;
	localparam int          SAVE_CYCLES     = SAVE_TIME_MS * (CLK_HZ / 1000);

	typedef enum logic [1:0]
	{
		ST_BOOT = 2'b00,
		ST_IDLE = 2'b01,
		ST_SAVE = 2'b10
	} ats_state_type;

	typedef struct packed
	{
		logic [7:0]  cmd_code;
		logic [7:0]  cmd_ext;
		logic [7:0]  sub_command_code;
		logic [15:0] sub_target_location;
		logic [15:0] sub_payload_value;
	} ats_cmd_type;

	typedef struct packed
	{
		logic [7:0]  sub_command_answer;
		logic [15:0] sub_target_location;
		logic [15:0] sub_payload_value;
		logic        command_ready_flag;
		logic        alarm;
		logic        warning;
	} ats_rsp_type;

endpackage

// ===== design/ats_nvm.sv
// small non-volatile store for saved tuning words
// assumes the array keeps its contents across reset; read data one cycle late
`timescale 1ns/10ps
module ats_nvm
	import ats_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        resetn_i,
	input  wire logic        we_i,
	input  wire logic [1:0]  waddr_i,
	input  wire logic [15:0] wdata_i,
	input  wire logic [1:0]  raddr_i,
	output logic      [15:0] rdata_o
);
	// no reset on the array: it models storage that outlives power-off
	logic [15:0] mem_reg [0:3];

	always_ff @(posedge clk_i)
	begin
		if (we_i)
		begin
			mem_reg[waddr_i] <= wdata_i;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			rdata_o <= 16'h0000;
		end
		else
		begin
			rdata_o <= mem_reg[raddr_i];
		end
	end
endmodule // ats_nvm

// ===== design/ats_core.sv
// adjust command interpreter for saving autotune results, plus tuning settings
// assumes synchronous inputs, one adjust frame per cmd_valid_i pulse, 10 MHz clock
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
module ats_core
	import ats_pkg::*;
#(
	parameter int SAVE_CYCLES_P = SAVE_CYCLES
)
(
	input  wire logic        clk_i,
	input  wire logic        resetn_i,
	input  wire logic        cmd_valid_i,
	input  wire ats_cmd_type cmd_i,
	output ats_rsp_type      rsp_o,
	output logic             rsp_valid_o,
	input  wire logic        est_valid_i,
	input  wire logic [15:0] est_ratio_i,
	output logic      [15:0] inertia_ratio_o,
	output logic             tuning_active_o,
	output logic             speed_fb_comp_en_o,
	output logic      [1:0]  friction_comp_o,
	input  wire logic [3:0]  reg_addr_i,
	input  wire logic [15:0] reg_wdata_i,
	input  wire logic        reg_write_i,
	input  wire logic        reg_read_i,
	output logic      [15:0] reg_rdata_o
);
	ats_state_type state_reg;
	logic [1:0]    boot_cnt_reg;
	logic          mark_ok_reg;
	logic [1:0]    wr_cnt_reg;
	logic [23:0]   save_cnt_reg;
	logic          write_mode_reg;
	logic          frozen_reg;
	logic [15:0]   load_inertia_ratio_reg;
	logic [3:0]    tuning_method_select_reg;
	logic [3:0]    speed_fb_comp_select_reg;
	logic [3:0]    friction_comp_select_reg;
	logic [15:0]   nvm_rdata;
	logic [1:0]    nvm_raddr;
	logic [15:0]   nvm_wdata;
	logic          nvm_we;
	logic          is_adjust;
	logic          is_mode;
	logic          is_exec;
	logic          exec_ok;
	logic          save_done;
	logic          sw_ratio_wr;
	logic          sw_opt_wr;
	logic [15:0]   est_clamped;
	logic [15:0]   opt_word;

	assign is_adjust = cmd_valid_i && cmd_i.cmd_code == ADJ_CODE && cmd_i.cmd_ext == ADJ_EXT;
	assign is_mode   = is_adjust && cmd_i.sub_command_code == SUB_DATA_SET
		&& cmd_i.sub_target_location == LOC_MODE && cmd_i.sub_payload_value == MODE_RESULTS_WR;
	assign is_exec   = is_adjust && cmd_i.sub_command_code == SUB_DATA_SET
		&& cmd_i.sub_target_location == LOC_EXEC && cmd_i.sub_payload_value == EXEC_VALUE;
	// execute without a prior mode select is refused, not started
	assign exec_ok   = is_exec && write_mode_reg && state_reg == ST_IDLE;
	assign save_done = state_reg == ST_SAVE && save_cnt_reg == 24'(SAVE_CYCLES_P - 1);
	assign sw_ratio_wr = reg_write_i && reg_addr_i == OFF_RATIO;
	assign sw_opt_wr   = reg_write_i && reg_addr_i == OFF_OPTION;
	assign est_clamped = (est_ratio_i > RATIO_CLAMP) ? RATIO_CLAMP : est_ratio_i;
	assign opt_word    = {4'h0, friction_comp_select_reg, speed_fb_comp_select_reg, tuning_method_select_reg};

	// marker read first so the other words can be taken or dropped as they arrive
	always_comb
	begin
		case (boot_cnt_reg)
			2'h0:    nvm_raddr = NVM_MARK;
			2'h1:    nvm_raddr = NVM_RATIO;
			default: nvm_raddr = NVM_OPTION;
		endcase
	end

	always_comb
	begin
		case (wr_cnt_reg)
			2'h0:    nvm_wdata = load_inertia_ratio_reg;
			2'h1:    nvm_wdata = opt_word;
			default: nvm_wdata = SAVE_MARK;
		endcase
	end
	// marker written last: a first save cut short before the marker write leaves no valid image
	assign nvm_we = state_reg == ST_SAVE && save_cnt_reg < 24'h000003;

	ats_nvm u_nvm
	(
		.clk_i    (clk_i),
		.resetn_i (resetn_i),
		.we_i     (nvm_we),
		.waddr_i  (wr_cnt_reg),
		.wdata_i  (nvm_wdata),
		.raddr_i  (nvm_raddr),
		.rdata_o  (nvm_rdata)
	);

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			state_reg    <= ST_BOOT;
			boot_cnt_reg <= 2'h0;
			mark_ok_reg  <= 1'b0;
		end
		else
		begin
			case (state_reg)
				ST_BOOT:
				begin
					boot_cnt_reg <= boot_cnt_reg + 2'h1;
					if (boot_cnt_reg == 2'h1)
					begin
						mark_ok_reg <= nvm_rdata == SAVE_MARK;
					end
					if (boot_cnt_reg == 2'h3)
					begin
						state_reg <= ST_IDLE;
					end
				end
				ST_IDLE:
				begin
					if (exec_ok)
					begin
						state_reg <= ST_SAVE;
					end
				end
				ST_SAVE:
				begin
					if (save_done)
					begin
						state_reg <= ST_IDLE;
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			save_cnt_reg <= 24'h000000;
			wr_cnt_reg   <= 2'h0;
		end
		else if (state_reg == ST_SAVE)
		begin
			save_cnt_reg <= save_cnt_reg + 24'h000001;
			if (wr_cnt_reg != 2'h3)
			begin
				wr_cnt_reg <= wr_cnt_reg + 2'h1;
			end
		end
		else
		begin
			save_cnt_reg <= 24'h000000;
			wr_cnt_reg   <= 2'h0;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			write_mode_reg <= 1'b0;
		end
		else if (save_done)
		begin
			write_mode_reg <= 1'b0;
		end
		else if (is_mode && state_reg == ST_IDLE)
		begin
			write_mode_reg <= 1'b1;
		end
	end

	// working ratio: reset default, saved image at boot, software, then estimates
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			load_inertia_ratio_reg <= RATIO_RESET;
			frozen_reg             <= 1'b0;
		end
		else if (state_reg == ST_BOOT)
		begin
			if (boot_cnt_reg == 2'h2 && mark_ok_reg)
			begin
				load_inertia_ratio_reg <= nvm_rdata;
			end
		end
		else if (sw_ratio_wr)
		begin
			if (reg_wdata_i <= RATIO_MAX)
			begin
				load_inertia_ratio_reg <= reg_wdata_i;
			end
		end
		else if (est_valid_i && tuning_active_o)
		begin
			load_inertia_ratio_reg <= est_clamped;
			if (tuning_method_select_reg == 4'h0)
			begin
				frozen_reg <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			tuning_method_select_reg <= METHOD_RESET;
			speed_fb_comp_select_reg <= SFB_RESET;
			friction_comp_select_reg <= FRIC_RESET;
		end
		else if (state_reg == ST_BOOT)
		begin
			if (boot_cnt_reg == 2'h3 && mark_ok_reg)
			begin
				tuning_method_select_reg <= nvm_rdata[METHOD_LSB +: 4];
				speed_fb_comp_select_reg <= nvm_rdata[SFB_LSB +: 4];
				friction_comp_select_reg <= nvm_rdata[FRIC_LSB +: 4];
			end
		end
		else if (sw_opt_wr)
		begin
			// out-of-range field values keep the old field
			if (reg_wdata_i[METHOD_LSB +: 4] <= 4'h2)
			begin
				tuning_method_select_reg <= reg_wdata_i[METHOD_LSB +: 4];
			end
			if (reg_wdata_i[SFB_LSB +: 4] <= 4'h1)
			begin
				speed_fb_comp_select_reg <= reg_wdata_i[SFB_LSB +: 4];
			end
			if (reg_wdata_i[FRIC_LSB +: 4] <= 4'h2)
			begin
				friction_comp_select_reg <= reg_wdata_i[FRIC_LSB +: 4];
			end
		end
	end

	assign tuning_active_o    = state_reg != ST_BOOT && (tuning_method_select_reg == 4'h1
		|| (tuning_method_select_reg == 4'h0 && !frozen_reg));
	assign inertia_ratio_o    = load_inertia_ratio_reg;
	assign speed_fb_comp_en_o = speed_fb_comp_select_reg == 4'h0;
	assign friction_comp_o    = friction_comp_select_reg[1:0];

	// answer to every adjust frame; ready follows the save, not the frame
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			rsp_o       <= '0;
			rsp_valid_o <= 1'b0;
		end
		else
		begin
			rsp_valid_o <= is_adjust;
			if (is_adjust)
			begin
				rsp_o.sub_command_answer  <= cmd_i.sub_command_code;
				rsp_o.sub_target_location <= cmd_i.sub_target_location;
				rsp_o.sub_payload_value   <= cmd_i.sub_payload_value;
				rsp_o.alarm               <= 1'b0;
				rsp_o.warning             <= !((is_mode && state_reg == ST_IDLE) || exec_ok);
				// a frame landing on the last save cycle must not swallow the ready set
				rsp_o.command_ready_flag  <= (!exec_ok && state_reg == ST_IDLE) || save_done;
			end
			else if (save_done)
			begin
				rsp_o.command_ready_flag <= 1'b1;
			end
			else if (state_reg == ST_IDLE)
			begin
				rsp_o.command_ready_flag <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			reg_rdata_o <= 16'h0000;
		end
		else if (reg_read_i)
		begin
			case (reg_addr_i)
				OFF_RATIO:  reg_rdata_o <= load_inertia_ratio_reg;
				OFF_OPTION: reg_rdata_o <= opt_word;
				OFF_STATUS: reg_rdata_o <= {11'h000, frozen_reg, tuning_active_o, state_reg == ST_SAVE,
					write_mode_reg, rsp_o.command_ready_flag};
				default:    reg_rdata_o <= 16'h0000;
			endcase
		end
		else
		begin
			reg_rdata_o <= 16'h0000;
		end
	end

	sequence mode_frame_s;
		is_mode && state_reg == ST_IDLE;
	endsequence

	sequence exec_frame_s;
		exec_ok;
	endsequence

	mode_enter_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		mode_frame_s |=> write_mode_reg && rsp_valid_o && rsp_o.command_ready_flag && !rsp_o.warning)
		else $error("mode select not answered ready");

	save_busy_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		exec_frame_s |=> !rsp_o.command_ready_flag && state_reg == ST_SAVE)
		else $error("ready high during save");

	save_bound_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		state_reg == ST_SAVE |-> save_cnt_reg < 24'(SAVE_CYCLES_P))
		else $error("save ran past its time");

	save_finish_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		save_done |=> state_reg == ST_IDLE && rsp_o.command_ready_flag && !write_mode_reg)
		else $error("save end not reported");

	answer_echo_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		is_adjust |=> rsp_o.sub_command_answer == $past(cmd_i.sub_command_code)
		&& rsp_o.sub_target_location == $past(cmd_i.sub_target_location)
		&& rsp_o.sub_payload_value == $past(cmd_i.sub_payload_value))
		else $error("answer does not echo frame");

	alarm_clear_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(mode_frame_s or exec_frame_s) |=> !rsp_o.alarm && !rsp_o.warning)
		else $error("good answer shows alarm or warning");

	ratio_range_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		sw_ratio_wr && reg_wdata_i > RATIO_MAX && state_reg != ST_BOOT
		|=> $stable(load_inertia_ratio_reg))
		else $error("ratio took out-of-range value");

	est_clamp_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		est_valid_i && tuning_active_o && !sw_ratio_wr && est_ratio_i > RATIO_CLAMP
		|=> load_inertia_ratio_reg == RATIO_CLAMP)
		else $error("estimate not clamped");

	method_freeze_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		tuning_method_select_reg == 4'h0 && frozen_reg |-> !tuning_active_o)
		else $error("method 0 kept tuning after first estimate");

	method_off_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		tuning_method_select_reg == 4'h2 |-> !tuning_active_o)
		else $error("tuning active with method 2");

	sfb_apply_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		speed_fb_comp_en_o == (speed_fb_comp_select_reg == 4'h0)
		&& speed_fb_comp_select_reg <= 4'h1)
		else $error("speed feedback setting not applied");

	boot_done_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		state_reg == ST_BOOT && boot_cnt_reg == 2'h3 |=> state_reg == ST_IDLE)
		else $error("boot load did not end");

endmodule // ats_core

// ===== sim/ats_host.sv
// host model for the adjust command port: single frames or the two-step save
// assumes answers and ready follow the command port timing of the core
`timescale 1ns/10ps
module ats_host
	import ats_pkg::*;
#(
	parameter int SAVE_P = 20
)
(
	input  wire logic        clk_i,
	input  wire logic        resetn_i,
	input  wire logic        send_i,
	input  wire ats_cmd_type frame_i,
	input  wire logic        save_i,
	input  wire ats_rsp_type rsp_i,
	input  wire logic        rsp_valid_i,
	output logic             cmd_valid_o,
	output ats_cmd_type      cmd_o,
	output logic             busy_o,
	output logic             fail_o
);
	localparam ats_cmd_type MODE_F = {ADJ_CODE, ADJ_EXT, SUB_DATA_SET, LOC_MODE, MODE_RESULTS_WR};
	localparam ats_cmd_type EXEC_F = {ADJ_CODE, ADJ_EXT, SUB_DATA_SET, LOC_EXEC, EXEC_VALUE};

	initial
	begin
		cmd_valid_o = 1'b0;
		cmd_o       = '0;
		busy_o      = 1'b0;
		fail_o      = 1'b0;
	end

	// ignored frames get no answer, so only save steps treat silence as a fault
	task automatic step(input ats_cmd_type f, input logic must, input int lim);
		int n;
		cmd_o       <= f;
		cmd_valid_o <= 1'b1;
		@(posedge clk_i);
		cmd_valid_o <= 1'b0;
		cmd_o       <= ~f;
		n = 0;
		while (rsp_valid_i !== 1'b1 && n < 4)
		begin
			@(posedge clk_i);
			n++;
		end
		if (must && (n == 4 || rsp_i.warning !== 1'b0))
			fail_o <= 1'b1;
		n = 0;
		while (rsp_i.command_ready_flag !== 1'b1 && n < lim)
		begin
			@(posedge clk_i);
			n++;
		end
		if (n == lim)
			fail_o <= 1'b1;
	endtask

	always @(posedge clk_i)
	begin
		if (resetn_i && !busy_o && (send_i || save_i))
		begin
			busy_o <= 1'b1;
			if (save_i)
			begin
				step(MODE_F, 1'b1, 8);
				step(EXEC_F, 1'b1, SAVE_P + 50);
			end
			else
				step(frame_i, 1'b0, 8);
			busy_o <= 1'b0;
		end
	end
endmodule // ats_host

// ===== sim/autotune_save_and_config_test.sv
// self-checking bench for ats_core with a host model on the command port
// assumes a short save count so the whole run stays small
`timescale 1ns/10ps
module autotune_save_and_config_test;
	import ats_pkg::*;
	localparam int SAVE = 20;
	logic        clk_i, resetn_i, cmd_valid_i, est_valid_i, reg_write_i, reg_read_i, rsp_valid_o;
	logic        send_i, save_i, busy, hfail, tuning_active_o, speed_fb_comp_en_o;
	logic [15:0] est_ratio_i, inertia_ratio_o, reg_wdata_i, reg_rdata_o, opt, w, v, sv;
	logic [3:0]  reg_addr_i;
	logic [1:0]  friction_comp_o;
	ats_cmd_type cmd_i, frame;
	ats_rsp_type rsp_o;
	ats_rsp_type rsps[$];
	int          n_mismatch, cmp_count, low_cnt, i;
	integer      seed = 32'hf99a198f;

	ats_core #(.SAVE_CYCLES_P(SAVE)) i_ats_core (.clk_i(clk_i), .resetn_i(resetn_i),
		.cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .rsp_o(rsp_o), .rsp_valid_o(rsp_valid_o),
		.est_valid_i(est_valid_i), .est_ratio_i(est_ratio_i), .inertia_ratio_o(inertia_ratio_o),
		.tuning_active_o(tuning_active_o), .speed_fb_comp_en_o(speed_fb_comp_en_o),
		.friction_comp_o(friction_comp_o), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_write_i(reg_write_i), .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o));
	ats_host #(.SAVE_P(SAVE)) i_ats_host (.clk_i(clk_i), .resetn_i(resetn_i), .send_i(send_i),
		.frame_i(frame), .save_i(save_i), .rsp_i(rsp_o), .rsp_valid_i(rsp_valid_o),
		.cmd_valid_o(cmd_valid_i), .cmd_o(cmd_i), .busy_o(busy), .fail_o(hfail));

	initial
	begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	always @(posedge clk_i)
	begin
		if (rsp_valid_o === 1'b1)
			rsps.push_back(rsp_o);
		if (rsp_o.command_ready_flag === 1'b0 && resetn_i)
			low_cnt++;
	end

	function automatic logic [15:0] opt_exp(input logic [15:0] o, input logic [15:0] x);
		opt_exp = o;
		if (x[3:0] <= 4'h2) opt_exp[3:0] = x[3:0];
		if (x[7:4] <= 4'h1) opt_exp[7:4] = x[7:4];
		if (x[11:8] <= 4'h2) opt_exp[11:8] = x[11:8];
	endfunction

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_i);
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		reg_write_i <= 1'b1;
		@(posedge clk_i);
		reg_write_i <= 1'b0;
		@(negedge clk_i);
	endtask

	task automatic rchk(input string nm, input logic [3:0] a, input logic [15:0] e);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_read_i <= 1'b1;
		@(posedge clk_i);
		reg_read_i <= 1'b0;
		@(negedge clk_i);
		chk(nm, e, reg_rdata_o);
		@(negedge clk_i);
		chk({nm, "_hold"}, 16'h0000, reg_rdata_o);
	endtask

	task automatic est(input logic [15:0] r);
		@(posedge clk_i);
		est_valid_i <= 1'b1;
		est_ratio_i <= r;
		@(posedge clk_i);
		est_valid_i <= 1'b0;
		est_ratio_i <= ~r;
		@(negedge clk_i);
	endtask

	// waits on the host model; a stuck host counts as a mismatch
	task automatic run_host(input logic sv_mode, input ats_cmd_type f);
		int n;
		n = 0;
		@(posedge clk_i);
		frame  <= f;
		send_i <= !sv_mode;
		save_i <= sv_mode;
		@(posedge clk_i);
		send_i <= 1'b0;
		save_i <= 1'b0;
		@(posedge clk_i);
		while (busy === 1'b1 && n < SAVE + 100)
		begin
			@(posedge clk_i);
			n++;
		end
		chk("host_busy", 16'h0, 16'(busy));
	endtask

	task automatic do_reset;
		@(posedge clk_i);
		resetn_i <= 1'b0;
		repeat (16) @(posedge clk_i);
		resetn_i <= 1'b1;
		repeat (6) @(posedge clk_i);
	endtask

	initial
	begin
		repeat (100000) @(posedge clk_i);
		n_mismatch++;
		give_verdict;
	end

	initial
	begin
		{resetn_i, est_valid_i, reg_write_i, reg_read_i, send_i, save_i} = '0;
		{est_ratio_i, reg_wdata_i, reg_addr_i, frame} = '0;
		do_reset;
		rchk("ratio_rst", OFF_RATIO, RATIO_RESET);
		rchk("option_rst", OFF_OPTION, OPTION_RESET);
		chk("sfb_rst", 16'h0, 16'(speed_fb_comp_en_o));
		rchk("status_rst", OFF_STATUS, 16'h0009);
		est(16'd100);
		chk("est_first", 16'd100, inertia_ratio_o);
		est(16'd200);
		chk("est_frozen", 16'd100, inertia_ratio_o);
		opt = OPTION_RESET;
		for (i = 0; i < 12; i++)
		begin
			w = (i < 3) ? {4'h0, 4'(i), 4'(i % 2), 4'(i)} : 16'($random(seed)) & 16'h0FFF;
			wr(OFF_OPTION, w);
			opt = opt_exp(opt, w);
			rchk("option", OFF_OPTION, opt);
			chk("sfb_en", 16'(opt[7:4] == 4'h0), 16'(speed_fb_comp_en_o));
			chk("fric", 16'(opt[9:8]), 16'(friction_comp_o));
		end
		wr(OFF_OPTION, 16'h0002);
		chk("tune_off", 16'h0, 16'(tuning_active_o));
		v = inertia_ratio_o;
		est(16'd500);
		chk("est_off", v, inertia_ratio_o);
		wr(OFF_OPTION, 16'h0001);
		for (i = 0; i < 10; i++)
		begin
			v = (i < 2) ? 16'(3000 + i) : 16'($unsigned($random(seed)) % 6000);
			est(v);
			chk("est_clamp", (v > 16'd3000) ? 16'd3000 : v, inertia_ratio_o);
		end
		wr(OFF_RATIO, 16'd10000);
		wr(OFF_RATIO, 16'd10001);
		rchk("ratio_max", OFF_RATIO, 16'd10000);
		chk("ratio_o", 16'd10000, inertia_ratio_o);
		rchk("unmapped", 4'hC, 16'h0000);
		i = rsps.size();
		run_host(1'b0, {8'h3D, ADJ_EXT, SUB_DATA_SET, LOC_MODE, MODE_RESULTS_WR});
		run_host(1'b0, {ADJ_CODE, 8'h01, SUB_DATA_SET, LOC_MODE, MODE_RESULTS_WR});
		chk("ignored", 16'(i), 16'(rsps.size()));
		run_host(1'b0, {ADJ_CODE, ADJ_EXT, SUB_DATA_SET, LOC_EXEC, EXEC_VALUE});
		chk("exec_early_warn", 16'h1, 16'(rsps[$].warning));
		chk("exec_early_loc", LOC_EXEC, rsps[$].sub_target_location);
		sv = 16'($unsigned($random(seed)) % 10001);
		wr(OFF_RATIO, sv);
		wr(OFF_OPTION, 16'h0201);
		low_cnt = 0;
		run_host(1'b1, '0);
		chk("host_fail", 16'h0, 16'(hfail));
		chk("mode_ans", 16'(SUB_DATA_SET), 16'(rsps[$-1].sub_command_answer));
		chk("mode_loc", LOC_MODE, rsps[$-1].sub_target_location);
		chk("mode_data", MODE_RESULTS_WR, rsps[$-1].sub_payload_value);
		chk("mode_flags", 16'h4, 16'({rsps[$-1].command_ready_flag, rsps[$-1].alarm, rsps[$-1].warning}));
		chk("exec_data", EXEC_VALUE, rsps[$].sub_payload_value);
		chk("exec_rdy", 16'h0, 16'(rsps[$].command_ready_flag));
		chk("save_low", 16'(SAVE), (low_cnt >= SAVE && low_cnt <= SAVE + 2) ? 16'(SAVE) : 16'(low_cnt));
		chk("save_done", 16'h1, 16'(rsp_o.command_ready_flag));
		wr(OFF_RATIO, sv ^ 16'h0001);
		wr(OFF_OPTION, 16'h0012);
		do_reset;
		rchk("ratio_saved", OFF_RATIO, sv);
		rchk("option_saved", OFF_OPTION, 16'h0201);
		rchk("status_saved", OFF_STATUS, 16'h0009);
		give_verdict;
	end
endmodule // autotune_save_and_config_test
